// ### design/rcmr_pkg.sv
package rcmr_pkg;

   // Register byte addresses on the peripheral bus.
   localparam logic [31:0] ADDR_SWAP_CTRL = 32'hffff0220;
   localparam logic [31:0] ADDR_CAUSE = 32'hffff0230;
   localparam logic [31:0] ADDR_CAUSE_CLEAR = 32'hffff0234;
   localparam logic [31:0] ADDR_KEY_FIRST = 32'hffff0248;
   localparam logic [31:0] ADDR_RET_CFG = 32'hffff024c;
   localparam logic [31:0] ADDR_KEY_SECOND = 32'hffff0250;

   // Field positions.
   localparam int SWAP_BIT = 0;
   localparam int CAUSE_POR_BIT = 0;
   localparam int CAUSE_WDT_BIT = 1;
   localparam int CAUSE_SW_BIT = 2;
   localparam int RET_GPIO_BIT = 0;
   localparam int RET_DAC_BIT = 2;

   // Reset values and masks.
   localparam logic [7:0] SWAP_RESET = 8'h00;
   localparam logic [7:0] RET_CFG_RESET = 8'h00;
   localparam logic [7:0] CAUSE_POR_VALUE = 8'h01;
   localparam logic [7:0] CAUSE_MASK = 8'h07;
   localparam logic [7:0] RET_CFG_MASK = 8'h05;

   // Unlock codes of the retention configuration sequence.
   localparam logic [7:0] KEY_FIRST_CODE = 8'h76;
   localparam logic [7:0] KEY_SECOND_CODE = 8'hb1;

   // Memory map of the core side.
   localparam logic [31:0] VECTOR_FIRST = 32'h00000000;
   localparam logic [31:0] VECTOR_LAST = 32'h00000020;
   localparam logic [31:0] MIRROR_SIZE = 32'h00080000;

   // Cycles spent in the reset state; the system reset pulse that this block issues lasts one cycle longer.
   localparam int RESET_HOLD_CYCLES = 4;

   // Kinds of reset event.
   typedef enum logic [2:0] {
      RCMR_SRC_NONE,
      RCMR_SRC_EXT,
      RCMR_SRC_WDT,
      RCMR_SRC_SW,
      RCMR_SRC_FAULT
   } rcmr_src_e;

   // Boot sequence states.
   typedef enum logic [1:0] {
      RCMR_ST_RESET,
      RCMR_ST_KERNEL,
      RCMR_ST_USER
   } rcmr_state_e;

   // Memory target of a core access to the bottom of the map.
   typedef struct packed {
      logic kernel;
      logic sram;
      logic nvm;
      logic vector;
   } rcmr_sel_s;

endpackage

// ### design/rcmr_top.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - Vector region spans 0x00000000 to 0x00000020, served by the bottom memory.
// - After any reset the nonvolatile memory is mirrored at the bottom.
// - Setting swap bit 0 mirrors SRAM at address zero instead.
// - Clearing swap bit 0 returns the nonvolatile memory to address zero.
// - Every reset clears the swap bit.
// - Every reset starts execution in a hidden factory kernel.
// - With boot select high, kernel finishes then jumps to address zero.
// - Five reset sources are recognised; watchdog and software causes add to the bits already recorded.
// - An external reset leaves all cause bits at zero.
// - Power-on reset sets the power-on cause bit.
// - Watchdog expiry sets the watchdog cause bit.
// - Writing 1 to the software bit forces a reset recorded there.
// - Writing 1 to a clear register bit clears that cause bit.
// - A clear leaving any set bit uncleared triggers a reset event.
// - DAC retention bit at 1 keeps DAC state through watchdog/software resets.
// - DAC retention bit at 0 returns DAC pins and registers to defaults.
// - GPIO retention bit likewise keeps or resets GPIO state.
// - Retention writes need key 0x76 before and key 0xB1 after.
module rcmr_top
   import rcmr_pkg::*;
#(
   parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
   input wire logic pclk, // Core clock.
   input wire logic presetn, // Power-on reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [31:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic ext_reset_n, // External reset pin, active low.
   input wire logic wdt_expire, // Watchdog expiry pulse, core clock.
   input wire logic boot_select_pin, // Boot select pin, high for normal.
   input wire logic kernel_done, // Kernel configuration routine finished.
   input wire logic [31:0] core_addr, // Core fetch or data address.
   input wire logic core_valid, // Core access strobe.
   output rcmr_sel_s core_sel, // Registered memory target.
   output logic sys_reset_n, // System reset to the rest of the chip.
   output logic dac_reset_n, // DAC reset, withheld when retained.
   output logic gpio_reset_n, // GPIO reset, withheld when retained.
   output logic vector_jump // Pulse: core jumps to the reset vector.
);

   logic [1:0] ext_sync;
   logic [1:0] boot_sync;
   logic ext_low_q;
   logic [7:0] swap_ctrl;
   logic [7:0] cause;
   logic [7:0] ret_cfg;
   logic [7:0] ret_pending;
   logic key_armed;
   logic cfg_pending;
   rcmr_state_e state;
   rcmr_src_e event_src;
   logic [$clog2(HOLD_CYCLES + 1) - 1:0] hold_cnt;
   logic setup;
   logic access_done;
   logic wr_done;
   logic mapped;
   logic in_reset;
   logic retain_ok;

   // True when the address falls on one of the mapped registers.
   function automatic logic is_mapped(input logic [31:0] a);
      if (a == ADDR_SWAP_CTRL) begin
         return 1'b1;
      end else if (a == ADDR_CAUSE || a == ADDR_CAUSE_CLEAR) begin
         return 1'b1;
      end else if (a == ADDR_KEY_FIRST || a == ADDR_KEY_SECOND) begin
         return 1'b1;
      end else if (a == ADDR_RET_CFG) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction

   // Pin inputs pass two flip-flops before anything reads them.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sync <= 2'h3;
         boot_sync <= 2'h0;
      end else begin
         ext_sync <= {ext_sync[0], ext_reset_n};
         boot_sync <= {boot_sync[0], boot_select_pin};
      end
   end

   // Remembers the synced pin level to catch its falling edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_low_q <= 1'b0;
      end else begin
         ext_low_q <= ~ext_sync[1];
      end
   end

   // Bus phase decode.
   assign setup = psel && !penable;
   assign access_done = psel && penable && pready;
   assign wr_done = access_done && pwrite;
   assign mapped = is_mapped(paddr);
   assign in_reset = (state == RCMR_ST_RESET);

   // Picks the reset source of this cycle; the external pin wins.
   always_comb begin
      event_src = RCMR_SRC_NONE;
      if (!ext_sync[1] && !ext_low_q) begin
         event_src = RCMR_SRC_EXT;
      end else if (wdt_expire) begin
         event_src = RCMR_SRC_WDT;
      end else if (wr_done && paddr == ADDR_CAUSE &&
                   pwdata[CAUSE_SW_BIT]) begin
         event_src = RCMR_SRC_SW;
      end else if (wr_done && paddr == ADDR_CAUSE_CLEAR &&
                   ((cause & CAUSE_MASK & ~pwdata[7:0]) != 8'h00)) begin
         event_src = RCMR_SRC_FAULT;
      end
   end

   // Retention only applies to watchdog and software resets.
   assign retain_ok = (event_src == RCMR_SRC_WDT) ||
                      (event_src == RCMR_SRC_SW);

   // APB answers without wait states; ready and read data leave flip-flops loaded in the setup phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= 32'h00000000;
         if (setup && !pwrite) begin
            if (paddr == ADDR_SWAP_CTRL) begin
               prdata <= {24'h000000, swap_ctrl};
            end else if (paddr == ADDR_CAUSE) begin
               prdata <= {24'h000000, cause};
            end else if (paddr == ADDR_RET_CFG) begin
               prdata <= {24'h000000, ret_cfg};
            end
         end
      end
   end

   // Reset cause record; hardware setting wins over a clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause <= CAUSE_POR_VALUE;
      end else begin
         case (event_src)
            RCMR_SRC_EXT, RCMR_SRC_FAULT: begin
               cause <= 8'h00;
            end
            RCMR_SRC_WDT: begin
               cause <= cause | (8'h01 << CAUSE_WDT_BIT);
            end
            RCMR_SRC_SW: begin
               cause <= cause | (8'h01 << CAUSE_SW_BIT);
            end
            default: begin
               if (wr_done && paddr == ADDR_CAUSE_CLEAR) begin
                  cause <= cause & ~pwdata[7:0];
               end
            end
         endcase
      end
   end

   // Swap control: cleared by any reset, software sets or clears bit 0.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swap_ctrl <= SWAP_RESET;
      end else if (event_src != RCMR_SRC_NONE || in_reset) begin
         swap_ctrl <= SWAP_RESET;
      end else if (wr_done && paddr == ADDR_SWAP_CTRL) begin
         swap_ctrl <= {7'h00, pwdata[SWAP_BIT]};
      end
   end

   // Unlock sequence for the retention configuration.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_armed <= 1'b0;
         cfg_pending <= 1'b0;
         ret_pending <= RET_CFG_RESET;
      end else if (event_src != RCMR_SRC_NONE || in_reset) begin
         key_armed <= 1'b0;
         cfg_pending <= 1'b0;
      end else if (wr_done) begin
         key_armed <= 1'b0;
         cfg_pending <= 1'b0;
         if (paddr == ADDR_KEY_FIRST && pwdata[7:0] == KEY_FIRST_CODE) begin
            key_armed <= 1'b1;
         end else if (paddr == ADDR_RET_CFG && key_armed) begin
            cfg_pending <= 1'b1;
            ret_pending <= pwdata[7:0] & RET_CFG_MASK;
         end
      end
   end

   // Retention configuration survives only retained reset kinds.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ret_cfg <= RET_CFG_RESET;
      end else if (event_src == RCMR_SRC_EXT ||
                   event_src == RCMR_SRC_FAULT) begin
         ret_cfg <= RET_CFG_RESET;
      end else if (wr_done && paddr == ADDR_KEY_SECOND && cfg_pending &&
                   pwdata[7:0] == KEY_SECOND_CODE) begin
         ret_cfg <= ret_pending;
      end
   end

   // Boot sequence: reset pulse, hidden kernel, then user code.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= RCMR_ST_RESET;
         hold_cnt <= '0;
         vector_jump <= 1'b0;
      end else begin
         vector_jump <= 1'b0;
         if (event_src != RCMR_SRC_NONE) begin
            state <= RCMR_ST_RESET;
            hold_cnt <= '0;
         end else begin
            case (state)
               RCMR_ST_RESET: begin
                  if (hold_cnt == ($bits(hold_cnt))'(HOLD_CYCLES - 1)) begin
                     state <= RCMR_ST_KERNEL;
                  end else begin
                     hold_cnt <= hold_cnt + 1'b1;
                  end
               end
               RCMR_ST_KERNEL: begin
                  if (kernel_done && boot_sync[1]) begin
                     state <= RCMR_ST_USER;
                     vector_jump <= 1'b1;
                  end
               end
               default: begin
                  state <= RCMR_ST_USER;
               end
            endcase
         end
      end
   end

   // Reset outputs; DAC and GPIO keep state when retained.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset_n <= 1'b0;
         dac_reset_n <= 1'b0;
         gpio_reset_n <= 1'b0;
      end else if (event_src != RCMR_SRC_NONE) begin
         sys_reset_n <= 1'b0;
         dac_reset_n <= retain_ok && ret_cfg[RET_DAC_BIT];
         gpio_reset_n <= retain_ok && ret_cfg[RET_GPIO_BIT];
      end else if (!in_reset) begin
         sys_reset_n <= 1'b1;
         dac_reset_n <= 1'b1;
         gpio_reset_n <= 1'b1;
      end
   end

   // Address routing; the swap bit takes effect the cycle after its write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_sel <= '0;
      end else begin
         core_sel <= '0;
         if (core_valid) begin
            if (state == RCMR_ST_KERNEL) begin
               core_sel.kernel <= 1'b1;
            end else if (core_addr < MIRROR_SIZE) begin
               core_sel.sram <= swap_ctrl[SWAP_BIT];
               core_sel.nvm <= !swap_ctrl[SWAP_BIT];
               core_sel.vector <= core_addr >= VECTOR_FIRST &&
                                  core_addr <= VECTOR_LAST;
            end
         end
      end
   end

endmodule

// ### verif/rcmr_assertions.sv
`timescale 1ns/1ps
// Ties resets, boot hand-over and memory routing to their causes.
module rcmr_assertions
   import rcmr_pkg::*;
#(
   parameter int HOLD_CYCLES = 1
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic psel, // Select.
   input wire logic penable, // Access phase.
   input wire logic pwrite, // Direction.
   input wire logic [31:0] paddr, // Address.
   input wire logic [31:0] pwdata, // Write data.
   input wire logic pready, // Ready.
   input wire logic wdt_expire, // Watchdog pulse.
   input wire logic kernel_done, // Kernel finished.
   input wire logic [31:0] core_addr, // Core address.
   input wire logic core_valid, // Core strobe.
   input wire rcmr_sel_s core_sel, // Memory target.
   input wire logic sys_reset_n, // System reset.
   input wire logic dac_reset_n, // DAC reset.
   input wire logic gpio_reset_n, // GPIO reset.
   input wire logic vector_jump // Jump pulse.
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   // A write completes at the edge where the access phase sees ready.
   assign wr = psel && penable && pready && pwrite;
   outside_map_a: assert property (core_valid && core_addr >= MIRROR_SIZE |=> core_sel[2:0] == 3'h0) else $error("High address routed to bottom memory.");
   vector_hit_a: assert property (core_valid && core_addr <= VECTOR_LAST |=> core_sel.vector || core_sel.kernel) else $error("Vector access not flagged.");
   mirror_one_a: assert property (core_valid && core_addr < MIRROR_SIZE |=> core_sel.kernel || core_sel.sram != core_sel.nvm) else $error("Bottom access not routed to one memory.");
   swap_set_a: assert property (wr && paddr == ADDR_SWAP_CTRL && pwdata[SWAP_BIT] ##[1:4] core_valid && core_addr < MIRROR_SIZE |=> core_sel.sram || core_sel.kernel) else $error("Swap set but memory not SRAM.");
   jump_cause_a: assert property (vector_jump |-> $past(kernel_done) && sys_reset_n) else $error("Jump without kernel done.");
   wdt_reset_a: assert property (wdt_expire |=> !sys_reset_n) else $error("Watchdog gave no reset.");
   reset_hold_a: assert property ($fell(sys_reset_n) |-> !sys_reset_n [*2]) else $error("System reset too short.");
   sw_reset_a: assert property (wr && paddr == ADDR_CAUSE && pwdata[CAUSE_SW_BIT] |=> !sys_reset_n) else $error("Software reset missing.");
   dac_follow_a: assert property (!dac_reset_n |-> !sys_reset_n) else $error("DAC reset outside system reset.");
   gpio_follow_a: assert property (!gpio_reset_n |-> !sys_reset_n) else $error("GPIO reset outside system reset.");
   cover property (vector_jump);
   cover property (wdt_expire);
   cover property (wr && paddr == ADDR_CAUSE_CLEAR);
endmodule

bind rcmr_top rcmr_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) i_rcmr_assertions (.*);

// ### verif/rcmr_core_model.sv
`timescale 1ns/1ps
// Core side: access strobes and the hidden kernel routine's completion.
module rcmr_core_model
   import rcmr_pkg::*;
#(
   parameter int KERNEL_LEN = 12
) (
   input wire logic pclk, // Clock.
   input wire logic sys_reset_n, // System reset from the block.
   input wire logic fetch_req, // Bench asks for one access.
   input wire logic [31:0] fetch_addr, // Address of that access.
   output logic [31:0] core_addr, // Address to the block.
   output logic core_valid, // Strobe to the block.
   output logic kernel_done // Kernel routine finished.
);
   logic [31:0] last_addr = 32'h0;
   int kcount = 0;
   // An idle bus shows the inverse of the last address, never a held one.
   assign core_valid = fetch_req;
   assign core_addr = fetch_req ? fetch_addr : ~last_addr;
   assign kernel_done = sys_reset_n && kcount == KERNEL_LEN;
   // The kernel restarts after every system reset and runs a fixed time.
   always_ff @(posedge pclk) begin
      if (fetch_req) begin
         last_addr <= fetch_addr;
      end
      if (!sys_reset_n) begin
         kcount <= 0;
      end else if (kcount < KERNEL_LEN) begin
         kcount <= kcount + 1;
      end
   end
endmodule

// ### verif/reset_cause_and_memory_remap_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) check_count++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end
module reset_cause_and_memory_remap_test;
   import rcmr_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, ext_reset_n = 1'b1, wdt_expire = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, fetch_addr = '0, prdata, core_addr;
   logic [31:0] rd;
   logic pready, pslverr, er, boot_select_pin = 1'b1, fetch_req = 1'b0;
   logic kernel_done, core_valid, sys_reset_n, dac_reset_n, gpio_reset_n;
   logic vector_jump;
   rcmr_sel_s core_sel;
   int bad_count = 0, check_count = 0;
   rcmr_top #(.HOLD_CYCLES(1)) i_rcmr_top (.*);
   rcmr_core_model i_rcmr_core_model (.*);
   // Clock of 25 ns.
   always #12.5 pclk = ~pclk;
   // One bus transfer; holds the request until ready is sampled high.
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // A bus that never answers counts as a mismatch.
      if (pready !== 1'b1) begin
         bad_count++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Reads one register and compares its low byte.
   task rdchk(input string nm, input logic [31:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd[7:0])
   endtask
   // One core access; the target is sampled in the cycle after it.
   task fetch(input logic [31:0] a, input logic [3:0] e);
      @(posedge pclk);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      @(posedge pclk);
      fetch_req <= 1'b0;
      @(posedge pclk);
      `CHK("core_sel", e, core_sel)
   endtask
   // Waits for the kernel to hand over to the reset vector.
   task wait_jump;
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (vector_jump !== 1'b1 && n < 200);
      `CHK("vector_jump", 1'b1, vector_jump)
   endtask
   task t_power;
      repeat (4) @(posedge pclk);
      fetch(32'h0, 4'h8);
      wait_jump;
      rdchk("cause", ADDR_CAUSE, 8'h01);
      rdchk("swap", ADDR_SWAP_CTRL, 8'h00);
      rdchk("unmapped", 32'hffff0240, 8'h00);
      `CHK("pslverr", 1'b1, er)
      $display("t_power done");
   endtask
   // Swaps while the core runs above the mirrored area.
   task t_swap;
      fetch(32'h00080020, 4'h0);
      apb(1'b1, ADDR_SWAP_CTRL, 32'h1);
      fetch(32'h10, 4'h5);
      fetch(32'h100, 4'h4);
      fetch(32'h00080020, 4'h0);
      apb(1'b1, ADDR_SWAP_CTRL, 32'h0);
      fetch(32'h20, 4'h3);
      $display("t_swap done");
   endtask
   task t_retain;
      apb(1'b1, ADDR_SWAP_CTRL, 32'h1);
      apb(1'b1, ADDR_RET_CFG, 32'h5);
      rdchk("cfg nokey", ADDR_RET_CFG, 8'h00);
      apb(1'b1, ADDR_KEY_FIRST, 32'h76);
      apb(1'b1, ADDR_RET_CFG, 32'h5);
      apb(1'b1, ADDR_KEY_SECOND, 32'hb1);
      rdchk("cfg", ADDR_RET_CFG, 8'h05);
      apb(1'b1, ADDR_CAUSE_CLEAR, 32'h1);
      rdchk("cause clr", ADDR_CAUSE, 8'h00);
      @(posedge pclk);
      wdt_expire <= 1'b1;
      @(posedge pclk);
      wdt_expire <= 1'b0;
      @(posedge pclk);
      `CHK("sys_reset_n", 1'b0, sys_reset_n)
      `CHK("dac_reset_n", 1'b1, dac_reset_n)
      `CHK("gpio_reset_n", 1'b1, gpio_reset_n)
      wait_jump;
      rdchk("cause wdt", ADDR_CAUSE, 8'h02);
      rdchk("swap", ADDR_SWAP_CTRL, 8'h00);
      $display("t_retain done");
   endtask
   // A clear that misses a set bit resets the device.
   task t_fault;
      apb(1'b1, ADDR_CAUSE_CLEAR, 32'h0);
      wait_jump;
      rdchk("cause", ADDR_CAUSE, 8'h00);
      rdchk("cfg", ADDR_RET_CFG, 8'h00);
      $display("t_fault done");
   endtask
   task t_soft;
      int n;
      apb(1'b1, ADDR_CAUSE, 32'h4);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sys_reset_n !== 1'b0 && n < 10);
      `CHK("dac_reset_n", 1'b0, dac_reset_n)
      `CHK("gpio_reset_n", 1'b0, gpio_reset_n)
      wait_jump;
      rdchk("cause sw", ADDR_CAUSE, 8'h04);
      $display("t_soft done");
   endtask
   task t_ext;
      @(posedge pclk);
      ext_reset_n <= 1'b0;
      repeat (4) @(posedge pclk);
      ext_reset_n <= 1'b1;
      wait_jump;
      rdchk("cause ext", ADDR_CAUSE, 8'h00);
      $display("t_ext done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #200000;
      bad_count++;
      final_report;
   end
   // Main sequence.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_power;
      t_swap;
      t_retain;
      t_fault;
      t_soft;
      t_ext;
      final_report;
   end
endmodule
